// ===== logic/status_word_bank_select.sv
// processor flags word and bank select registers
// Function
// - low flags nibble at FB0H is read/write
// - memory writes to FB1H nibble are ignored
// - calls push, plain returns restore, only expand flags
// - interrupt entry pushes, exit restores whole word
// - add/subtract with carry record carry out
// - carry value after reset is undefined
// - set, clear, invert, test-skip on carry
// - carry load/store/and/or/xor with memory bit
// - bypass flags update automatically, not operands
// - nesting codes: 00 all, 01 higher, 10 none
// - entry saves level then advances; exit restores
// - memory expand selects upper address nibble source
// - reset loads memory expand from word0 bit7
// - reset loads register expand from word0 bit6
// - vector entry bits 7/6 load expand flags
// - register expand selects bank, else bank 0
// - memory bank choice only 0-3 or 15
// - reset clears both bank choice registers
// - register bank choice 0-3, upper bits zero
// - bank select byte pushed/popped as one
`timescale 1ns/1ns
`default_nettype none
module status_word_bank_select (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // sequencer
  input wire psw_pkg::op_e op_i,
  input wire logic [3:0] op_arg_i,
  input wire logic instr_end_i,
  input wire logic [2:0] seq_skip_i,
  input wire logic alu_carry_i,
  input wire logic bit_i,
  input wire logic [7:0] rom_word0_i,
  input wire logic [7:0] vector_i,
  // data memory access
  input wire logic [11:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic [3:0] mem_wdata_i,
  output logic [3:0] mem_rdata_o,
  // stack
  input wire logic [7:0] stack_rdata_i,
  output logic stack_push_o,
  output logic [7:0] stack_wdata_o,
  // memory bit write from carry
  output logic bit_wr_o,
  output logic bit_wdata_o,
  // status
  output logic [7:0] flags_o,
  output logic [7:0] bank_select_o,
  output logic [3:0] data_bank_o,
  output logic [1:0] reg_bank_o
);
  import psw_pkg::*;

  logic cy_reg;
  logic [2:0] skip_reg;
  logic [1:0] ist_reg;
  logic mbe_reg;
  logic rbe_reg;
  logic [3:0] mbs_reg;
  logic [3:0] rbs_reg;
  logic boot_reg;
  logic push_reg;
  logic [7:0] push_data_reg;
  logic [3:0] rdata_reg;
  logic bit_wr_reg;
  logic bit_data_reg;
  logic [3:0] data_bank_reg;
  logic [1:0] reg_bank_reg;

  // only banks 0..3 and 15 exist in the data space
  function automatic logic legal_bank(input logic [3:0] n);
    legal_bank = (n <= LAST_LOW_BANK) || (n == TOP_BANK);
  endfunction

  // decode
  wire idle_op = (op_i == OP_NONE);
  wire is_call = (op_i == OP_CALL) || (op_i == OP_CALL_ABS)
    || (op_i == OP_CALL_FAST);
  wire is_ret = (op_i == OP_RET) || (op_i == OP_RET_SKIP);
  wire is_interrupt_exit = (op_i == OP_INTERRUPT_EXIT);
  // entry at level 10 is refused so an entry never advances the level to 11
  wire take_int = (op_i == OP_INT_ENTRY) && (ist_reg != IST_TWO)
    && !boot_reg;
  // memory writes only land in the low nibble
  wire lo_wr = mem_wr_i && (mem_addr_i == FLAGS_LO_ADDR)
    && idle_op && !boot_reg;
  wire skt_hit = (op_i == OP_SKT_CY) && cy_reg;
  wire [7:0] flags_word = {cy_reg, skip_reg, ist_reg, mbe_reg, rbe_reg};
  wire [7:0] bank_word = {mbs_reg, rbs_reg};

  // carry
  wire cy_next =
    boot_reg ? cy_reg :
    (op_i == OP_SET_CY) ? 1'b1 :
    (op_i == OP_CLR_CY) ? 1'b0 :
    (op_i == OP_NOT_CY) ? ~cy_reg :
    (op_i == OP_LD_CY_BIT) ? bit_i :
    (op_i == OP_AND_BIT) ? (cy_reg & bit_i) :
    (op_i == OP_OR_BIT) ? (cy_reg | bit_i) :
    (op_i == OP_XOR_BIT) ? (cy_reg ^ bit_i) :
    (op_i == OP_ADD_WITH_CARRY) ? alu_carry_i :
    (op_i == OP_SUBTRACT_WITH_BORROW) ? alu_carry_i :
    is_interrupt_exit ? stack_rdata_i[CY_BIT] :
    cy_reg;

  // bypass flags follow the sequencer, never a memory write
  wire [2:0] skip_next =
    is_interrupt_exit ? stack_rdata_i[SK_MSB:SK_LSB] :
    instr_end_i ? {seq_skip_i[2:1], seq_skip_i[0] | skt_hit} :
    skip_reg;

  // nesting level
  wire [1:0] ist_next =
    boot_reg ? ist_reg :
    take_int ? ist_reg + 2'h1 :
    is_interrupt_exit ? stack_rdata_i[IST_MSB:IST_LSB] :
    lo_wr ? mem_wdata_i[IST_MSB:IST_LSB] :
    ist_reg;

  // expand flags
  wire mbe_next =
    boot_reg ? rom_word0_i[ROM_MBE_BIT] :
    take_int ? vector_i[ROM_MBE_BIT] :
    (is_ret || is_interrupt_exit) ? stack_rdata_i[MBE_BIT] :
    lo_wr ? mem_wdata_i[MBE_BIT] :
    mbe_reg;
  wire rbe_next =
    boot_reg ? rom_word0_i[ROM_RBE_BIT] :
    take_int ? vector_i[ROM_RBE_BIT] :
    (is_ret || is_interrupt_exit) ? stack_rdata_i[RBE_BIT] :
    lo_wr ? mem_wdata_i[RBE_BIT] :
    rbe_reg;

  // bank choices; an illegal memory bank value is ignored
  wire [3:0] pop_mbs = stack_rdata_i[MBS_MSB:MBS_LSB];
  wire [3:0] mbs_next =
    ((op_i == OP_SEL_MB) && legal_bank(op_arg_i)) ? op_arg_i :
    ((op_i == OP_BANK_STACK_LOAD) && legal_bank(pop_mbs)) ? pop_mbs :
    mbs_reg;
  wire [3:0] rbs_next =
    (op_i == OP_SEL_RB) ? {2'h0, op_arg_i[1:0]} :
    (op_i == OP_BANK_STACK_LOAD) ? {2'h0, stack_rdata_i[RBS_MSB:RBS_LSB]} :
    rbs_reg;

  // stack pushes
  wire push_next = is_call || take_int || (op_i == OP_BANK_STACK_STORE);
  wire [7:0] push_data_next =
    take_int ? flags_word :
    (op_i == OP_BANK_STACK_STORE) ? bank_word :
    is_call ? {6'h00, mbe_reg, rbe_reg} :
    push_data_reg;

  // address generation follows the values being stored
  wire [3:0] data_bank_next = mbe_next ? mbs_next : FIXED_BANK;
  wire [1:0] reg_bank_next = rbe_next ? rbs_next[1:0] : 2'h0;
  // the high nibble reads back as zero to plain memory reads
  wire [3:0] rdata_next = (mem_addr_i == FLAGS_LO_ADDR) ?
    {ist_reg, mbe_reg, rbe_reg} : 4'h0;

  // carry keeps a reset only so simulation starts clean
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cy_reg <= CY_RESET;
    end else begin
      cy_reg <= cy_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      skip_reg <= SK_RESET;
      ist_reg <= IST_RESET;
      mbe_reg <= 1'b0;
      rbe_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      skip_reg <= skip_next;
      ist_reg <= ist_next;
      mbe_reg <= mbe_next;
      rbe_reg <= rbe_next;
      boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mbs_reg <= BANK_RESET;
      rbs_reg <= BANK_RESET;
      data_bank_reg <= FIXED_BANK;
      reg_bank_reg <= 2'h0;
    end else begin
      mbs_reg <= mbs_next;
      rbs_reg <= rbs_next;
      data_bank_reg <= data_bank_next;
      reg_bank_reg <= reg_bank_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      push_reg <= 1'b0;
      push_data_reg <= 8'h00;
      rdata_reg <= 4'h0;
      bit_wr_reg <= 1'b0;
      bit_data_reg <= 1'b0;
    end else begin
      push_reg <= push_next;
      push_data_reg <= push_data_next;
      rdata_reg <= rdata_next;
      bit_wr_reg <= (op_i == OP_ST_CY_BIT);
      bit_data_reg <= cy_reg;
    end
  end

  assign flags_o = {cy_reg, skip_reg, ist_reg, mbe_reg, rbe_reg};
  assign bank_select_o = {mbs_reg, rbs_reg};
  assign data_bank_o = data_bank_reg;
  assign reg_bank_o = reg_bank_reg;
  assign stack_push_o = push_reg;
  assign stack_wdata_o = push_data_reg;
  assign mem_rdata_o = rdata_reg;
  assign bit_wr_o = bit_wr_reg;
  assign bit_wdata_o = bit_data_reg;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence hi_write_s;
    mem_wr_i && (mem_addr_i == FLAGS_HI_ADDR) && idle_op && !instr_end_i;
  endsequence

  sequence lo_write_s;
    mem_wr_i && (mem_addr_i == FLAGS_LO_ADDR) && idle_op && !boot_reg;
  endsequence

  sequence int_accept_s;
    (op_i == OP_INT_ENTRY) && (flags_o[3:2] != IST_TWO) && !boot_reg;
  endsequence

  sequence int_refuse_s;
    (op_i == OP_INT_ENTRY) && (flags_o[3:2] == IST_TWO);
  endsequence

  hi_nibble_locked_a: assert property (
    hi_write_s |=> $stable(flags_o[7:4]))
    else $error("high flags nibble changed by memory write");

  lo_nibble_write_a: assert property (
    lo_write_s |=> flags_o[3:0] == $past(mem_wdata_i))
    else $error("low flags nibble not written");

  lo_nibble_read_a: assert property (
    (mem_addr_i == FLAGS_LO_ADDR) |=> mem_rdata_o == $past(flags_o[3:0]))
    else $error("low flags nibble read wrong");

  call_push_a: assert property (
    (is_call && !boot_reg) |=> stack_push_o
      && stack_wdata_o == {6'h00, $past(flags_o[1:0])}
      // bypass flags may still move with the instruction end
      && flags_o[7] == $past(flags_o[7])
      && flags_o[3:2] == $past(flags_o[3:2]))
    else $error("call push wrong");

  ret_restore_a: assert property (
    (is_ret && !boot_reg) |=> flags_o[1:0] == $past(stack_rdata_i[1:0])
      && flags_o[7] == $past(flags_o[7])
      && flags_o[3:2] == $past(flags_o[3:2]))
    else $error("return restore wrong");

  int_entry_push_a: assert property (
    int_accept_s |=> stack_push_o && stack_wdata_o == $past(flags_o)
      && flags_o[3:2] == $past(flags_o[3:2]) + 2'h1)
    else $error("interrupt entry push or advance wrong");

  int_vector_load_a: assert property (
    int_accept_s |=> flags_o[1] == $past(vector_i[7])
      && flags_o[0] == $past(vector_i[6]))
    else $error("vector expand flags not loaded");

  interrupt_exit_restore_a: assert property (
    (is_interrupt_exit && !boot_reg) |=> flags_o == $past(stack_rdata_i))
    else $error("interrupt exit restore wrong");

  level_cap_a: assert property (
    int_refuse_s |=> !stack_push_o && flags_o[3:2] == IST_TWO)
    else $error("nesting level advanced past two");

  arith_carry_a: assert property (
    ((op_i == OP_ADD_WITH_CARRY) || (op_i == OP_SUBTRACT_WITH_BORROW)) && !boot_reg
      |=> flags_o[7] == $past(alu_carry_i))
    else $error("arithmetic carry not recorded");

  carry_invert_a: assert property (
    (op_i == OP_NOT_CY) && !boot_reg |=> flags_o[7] != $past(flags_o[7]))
    else $error("carry not inverted");

  carry_xor_a: assert property (
    (op_i == OP_XOR_BIT) && !boot_reg
      |=> flags_o[7] == ($past(flags_o[7]) ^ $past(bit_i)))
    else $error("carry xor wrong");

  boot_load_a: assert property (
    boot_reg |=> flags_o[1:0] == $past(rom_word0_i[7:6])
      && bank_select_o == 8'h00)
    else $error("reset word expand flags not loaded");

  data_bank_a: assert property (
    !boot_reg |-> data_bank_o == (flags_o[1] ? bank_select_o[7:4] : FIXED_BANK))
    else $error("data bank source wrong");

  reg_bank_a: assert property (
    !boot_reg |-> reg_bank_o == (flags_o[0] ? bank_select_o[1:0] : 2'h0))
    else $error("register bank source wrong");

  bank_legal_a: assert property (
    legal_bank(bank_select_o[7:4]) && bank_select_o[3:2] == 2'h0)
    else $error("illegal bank choice held");

  bank_push_a: assert property (
    (op_i == OP_BANK_STACK_STORE) |=> stack_push_o
      && stack_wdata_o == $past(bank_select_o))
    else $error("bank select push wrong");

  carry_force_a: assert property (
    ((op_i == OP_SET_CY) || (op_i == OP_CLR_CY)) && !boot_reg
      |=> flags_o[7] == ($past(op_i) == OP_SET_CY))
    else $error("carry not forced");

  carry_store_a: assert property (
    (op_i == OP_ST_CY_BIT) |=> bit_wr_o && bit_wdata_o == $past(flags_o[7]))
    else $error("carry store to memory bit wrong");

  skip_load_a: assert property (
    instr_end_i && (op_i != OP_INTERRUPT_EXIT) && (op_i != OP_SKT_CY)
      |=> flags_o[6:4] == $past(seq_skip_i))
    else $error("bypass flags not loaded");

  level_wrap_a: assert property (
    int_accept_s |=> flags_o[3:2] != 2'h3)
    else $error("nesting level reached code 11");

  bank_pop_a: assert property (
    (op_i == OP_BANK_STACK_LOAD) |=> bank_select_o[3:0] == {2'h0, $past(stack_rdata_i[1:0])})
    else $error("bank select pop wrong");

endmodule
`default_nettype wire

// ===== logic/psw_pkg.sv
// constants and opcodes for the status word and bank select block
`default_nettype none
package psw_pkg;
  // data memory placement of the flags word
  localparam logic [11:0] FLAGS_LO_ADDR = 12'hFB0;
  localparam logic [11:0] FLAGS_HI_ADDR = 12'hFB1;
  // field positions in the 8-bit flags word
  localparam int CY_BIT = 7;
  localparam int SK_MSB = 6;
  localparam int SK_LSB = 4;
  localparam int IST_MSB = 3;
  localparam int IST_LSB = 2;
  localparam int MBE_BIT = 1;
  localparam int RBE_BIT = 0;
  // field positions in a program word (reset word and vector entry)
  localparam int ROM_MBE_BIT = 7;
  localparam int ROM_RBE_BIT = 6;
  // field positions in the bank select byte
  localparam int MBS_MSB = 7;
  localparam int MBS_LSB = 4;
  localparam int RBS_MSB = 1;
  localparam int RBS_LSB = 0;
  // values after reset; the carry value is arbitrary, software may not rely on it
  localparam logic CY_RESET = 1'b0;
  localparam logic [2:0] SK_RESET = 3'h0;
  localparam logic [1:0] IST_RESET = 2'h0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  // bank values
  localparam logic [3:0] FIXED_BANK = 4'h0;
  localparam logic [3:0] LAST_LOW_BANK = 4'h3;
  localparam logic [3:0] TOP_BANK = 4'hF;
  // nesting levels
  localparam logic [1:0] IST_IDLE = 2'h0;
  localparam logic [1:0] IST_ONE = 2'h1;
  localparam logic [1:0] IST_TWO = 2'h2;
  // operations presented by the sequencer, one per cycle
  typedef enum logic [4:0] {
    OP_NONE, OP_SET_CY, OP_CLR_CY, OP_NOT_CY, OP_SKT_CY,
    OP_LD_CY_BIT, OP_ST_CY_BIT, OP_AND_BIT, OP_OR_BIT, OP_XOR_BIT,
    OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_CALL, OP_CALL_ABS, OP_CALL_FAST,
    OP_RET, OP_RET_SKIP, OP_INTERRUPT_EXIT, OP_INT_ENTRY,
    OP_SEL_RB, OP_SEL_MB, OP_BANK_STACK_STORE, OP_BANK_STACK_LOAD
  } op_e;
endpackage
`default_nettype wire

// ===== testbench/seq_stack_model.sv
// stack memory model standing in for the sequencer side
`timescale 1ns/1ns
`default_nettype none
module seq_stack_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // block side
  input wire psw_pkg::op_e op_i,
  input wire logic stack_push_i,
  input wire logic [7:0] stack_wdata_i,
  output logic [7:0] stack_rdata_o
);
  import psw_pkg::*;
  logic [7:0] mem_reg [0:7];
  logic [2:0] sp_reg;
  logic [7:0] junk_reg;
  logic pop;
  assign pop = (op_i == OP_RET) || (op_i == OP_RET_SKIP) ||
               (op_i == OP_INTERRUPT_EXIT) || (op_i == OP_BANK_STACK_LOAD);
  // an empty stack shows a changing pattern, never a stale byte
  assign stack_rdata_o = (sp_reg == 3'h0) ? junk_reg : mem_reg[sp_reg - 3'h1];
  always_ff @(posedge mclk_i) begin
    junk_reg <= (!rst_b_i) ? 8'h5A : ~junk_reg;
    if (!rst_b_i) begin
      sp_reg <= 3'h0;
    end else if (stack_push_i) begin
      mem_reg[sp_reg] <= stack_wdata_i;
      sp_reg <= sp_reg + 3'h1;
    end else if (pop && sp_reg != 3'h0) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the flags word and bank select block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import psw_pkg::*;
  logic mclk_i, rst_b_i, instr_end_i, mem_wr_i, stack_push_o, bit_wr_o, bit_wdata_o;
  op_e op_i;
  logic [3:0] op_arg_i = 4'h0;
  logic [2:0] seq_skip_i = 3'h0;
  logic alu_carry_i = 1'b0;
  logic bit_i = 1'b0;
  logic [7:0] rom_word0_i, stack_rdata_i, stack_wdata_o, flags_o, bank_select_o;
  logic [7:0] vector_i = 8'h00;
  logic [11:0] mem_addr_i = 12'h000;
  logic [3:0] mem_wdata_i = 4'h0;
  logic [3:0] mem_rdata_o, data_bank_o;
  logic [1:0] reg_bank_o;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  op_e cy_ops [9] = '{OP_SET_CY, OP_CLR_CY, OP_NOT_CY, OP_LD_CY_BIT, OP_OR_BIT,
                      OP_AND_BIT, OP_XOR_BIT, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW};
  logic [8:0] cy_in = 9'b101010000;
  logic [8:0] cy_exp = 9'b101010101;
  logic [3:0] mb_arg [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'h5};
  logic [3:0] mb_exp [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'hF};
  op_e call_ops [3] = '{OP_CALL, OP_CALL_ABS, OP_CALL_FAST};
  op_e ret_ops [3] = '{OP_RET, OP_RET_SKIP, OP_RET};

  status_word_bank_select uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_i(op_i),
    .op_arg_i(op_arg_i), .instr_end_i(instr_end_i), .seq_skip_i(seq_skip_i),
    .alu_carry_i(alu_carry_i), .bit_i(bit_i), .rom_word0_i(rom_word0_i),
    .vector_i(vector_i), .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i),
    .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o), .stack_rdata_i(stack_rdata_i),
    .stack_push_o(stack_push_o), .stack_wdata_o(stack_wdata_o), .bit_wr_o(bit_wr_o),
    .bit_wdata_o(bit_wdata_o), .flags_o(flags_o), .bank_select_o(bank_select_o),
    .data_bank_o(data_bank_o), .reg_bank_o(reg_bank_o));
  seq_stack_model stack_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_i(op_i),
    .stack_push_i(stack_push_o), .stack_wdata_i(stack_wdata_o),
    .stack_rdata_o(stack_rdata_i));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task results;
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // boot cycle follows release, so the first op waits for the second edge
  task automatic do_reset(input logic [7:0] w);
    rst_b_i = 1'b0;
    op_i = OP_NONE;
    mem_wr_i = 1'b0;
    instr_end_i = 1'b0;
    rom_word0_i = w;
    repeat (12) @(posedge mclk_i);
    #5 rst_b_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #5;
  endtask

  // op is left standing; the next call replaces it, so none is sent twice
  task automatic do_op(input op_e o, input logic [3:0] a, input logic b, input logic ie);
    op_i = o;
    op_arg_i = a;
    bit_i = b;
    alu_carry_i = b;
    instr_end_i = ie;
    mem_wr_i = 1'b0;
    @(posedge mclk_i);
    #5;
  endtask

  task automatic mem(input logic [11:0] ad, input logic w, input logic [3:0] d);
    op_i = OP_NONE;
    instr_end_i = 1'b0;
    mem_addr_i = ad;
    mem_wr_i = w;
    mem_wdata_i = d;
    @(posedge mclk_i);
    #5;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    do_reset(8'hC0);
    chk(flags_o & 8'h7F, 8'h03);
    chk(bank_select_o, 8'h00);
    for (int i = 0; i < 6; i++) begin
      do_op(OP_SEL_MB, mb_arg[i], 1'b0, 1'b0);
      chk(bank_select_o, {mb_exp[i], 4'h0});
      chk({4'h0, data_bank_o}, {4'h0, mb_exp[i]});
    end
    do_op(OP_SEL_RB, 4'h7, 1'b0, 1'b0);
    chk(bank_select_o, 8'hF3);
    chk({6'h0, reg_bank_o}, 8'h03);
    for (int i = 0; i < 9; i++) begin
      do_op(cy_ops[i], 4'h0, cy_in[i], 1'b0);
      chk({7'h0, flags_o[7]}, {7'h0, cy_exp[i]});
    end
    do_op(OP_ST_CY_BIT, 4'h0, 1'b0, 1'b0);
    chk({6'h0, bit_wr_o, bit_wdata_o}, 8'h03);
    do_op(OP_SKT_CY, 4'h0, 1'b0, 1'b1);
    chk(flags_o & 8'h70, 8'h10);
    seq_skip_i = 3'h6;
    do_op(OP_NONE, 4'h0, 1'b0, 1'b1);
    chk(flags_o & 8'h70, 8'h60);
    // level rewrite done as if interrupts were held off around it
    mem(FLAGS_LO_ADDR, 1'b1, 4'h4);
    chk(flags_o, 8'hE4);
    chk({data_bank_o, 2'h0, reg_bank_o}, 8'h00);
    mem(FLAGS_LO_ADDR, 1'b0, 4'h0);
    chk({4'h0, mem_rdata_o}, 8'h04);
    mem(FLAGS_HI_ADDR, 1'b1, 4'h0);
    chk(flags_o, 8'hE4);
    chk({4'h0, mem_rdata_o}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      mem(FLAGS_LO_ADDR, 1'b1, 4'h3);
      do_op(call_ops[i], 4'h0, 1'b0, 1'b0);
      chk({stack_push_o, 5'h0, stack_wdata_o[1:0]}, 8'h83);
      mem(FLAGS_LO_ADDR, 1'b1, 4'h4);
      do_op(ret_ops[i], 4'h0, 1'b0, 1'b0);
      chk(flags_o, 8'hE7);
    end
    mem(FLAGS_LO_ADDR, 1'b1, 4'h3);
    vector_i = 8'h40;
    do_op(OP_INT_ENTRY, 4'h0, 1'b0, 1'b0);
    chk(stack_wdata_o, 8'hE3);
    chk(flags_o, 8'hE5);
    vector_i = 8'h80;
    do_op(OP_INT_ENTRY, 4'h0, 1'b0, 1'b0);
    chk(flags_o, 8'hEA);
    vector_i = 8'h40;
    do_op(OP_INT_ENTRY, 4'h0, 1'b0, 1'b0);
    chk({7'h0, stack_push_o}, 8'h00);
    do_op(OP_CLR_CY, 4'h0, 1'b0, 1'b0);
    chk(flags_o, 8'h6A);
    do_op(OP_INTERRUPT_EXIT, 4'h0, 1'b0, 1'b0);
    chk(flags_o, 8'hE5);
    do_op(OP_INTERRUPT_EXIT, 4'h0, 1'b0, 1'b0);
    chk(flags_o, 8'hE3);
    do_op(OP_BANK_STACK_STORE, 4'h0, 1'b0, 1'b0);
    chk(stack_wdata_o, 8'hF3);
    do_op(OP_SEL_MB, 4'h1, 1'b0, 1'b0);
    do_op(OP_SEL_RB, 4'h0, 1'b0, 1'b0);
    do_op(OP_BANK_STACK_LOAD, 4'h0, 1'b0, 1'b0);
    chk(bank_select_o, 8'hF3);
    do_reset(8'h40);
    chk(flags_o & 8'h7F, 8'h01);
    chk({data_bank_o, bank_select_o[3:0]}, 8'h00);
    results();
  end
endmodule
`default_nettype wire
